// ===== design/ccu_cfg.svh
// offsets, field positions, reset values and timing counts of the clock control unit
`ifndef CCU_CFG_SVH
`define CCU_CFG_SVH
// register byte offsets
`define CCU_OFS_OSC        12'h000
`define CCU_OFS_SWCTL      12'h004
`define CCU_OFS_SWTGT      12'h008
`define CCU_OFS_DIV        12'h00C
`define CCU_OFS_GATE       12'h010
`define CCU_OFS_MISC       12'h014
// oscillator control fields
`define CCU_OSC_FINT       0
`define CCU_OSC_FEXT       1
`define CCU_OSC_SINT       2
`define CCU_OSC_REGOFF     3
`define CCU_OSC_FWAKE      4
`define CCU_OSC_RDY_LSB    8
// switch control fields
`define CCU_SW_EN          0
`define CCU_SW_BUSY        1
`define CCU_SW_IRQEN       2
`define CCU_SW_AUTO        3
`define CCU_SW_OLDOFF      4
`define CCU_SW_DONE        5
`define CCU_SW_FAIL        6
`define CCU_SW_AUX         7
`define CCU_SW_CUR_LSB     8
// reset values
`define CCU_RST_OSC        3'h1
`define CCU_RST_GATE       15'h7FFF
`define CCU_RST_FINT_DIV   2'h3
`define CCU_RST_CPU_DIV    3'h0
`define CCU_RST_DBG_DIV2   1'h1
`define CCU_RST_PLL_DIV    2'h2
`define CCU_RST_AWU_DIV    3'h0
`define CCU_RST_CCO_DIV    3'h0
`define CCU_RST_CONV_DIV   2'h3
// switch stabilization timeout
`define CCU_CLK_MHZ        25
`define CCU_SW_TIMEOUT_US  1000
`define CCU_SW_TIMEOUT_CYC (`CCU_SW_TIMEOUT_US * `CCU_CLK_MHZ)
`endif

// ===== design/ccu_pkg.sv
// types shared by the clock control unit
package ccu_pkg;
   // master clock sources
   typedef enum logic [1:0] {
      CCU_SRC_FINT = 2'h0,
      CCU_SRC_SINT = 2'h1,
      CCU_SRC_FEXT = 2'h2
   } ccu_src_t;
   // switch sequencer states, one-hot
   typedef enum logic [2:0] {
      CCU_SW_IDLE   = 3'h1,
      CCU_SW_WAIT   = 3'h2,
      CCU_SW_COMMIT = 3'h4
   } ccu_swst_t;
   // oscillator enables, index matches ready bits
   typedef struct packed {
      logic sint;
      logic fext;
      logic fint;
   } ccu_osc_t;
   // divider and derived-clock settings
   typedef struct packed {
      logic [1:0] fint_div;
      logic [2:0] cpu_div;
      logic       dbg_div2;
      logic       pll_en;
      logic [1:0] pll_div;
      logic [2:0] awu_div;
      logic [2:0] cco_div;
      logic [1:0] conv_div;
      logic       esm_src;
   } ccu_div_t;
endpackage : ccu_pkg

// ===== design/ccu_clock_control_unit.sv
// clock control unit: oscillator control, master clock switch, dividers and gates
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "ccu_cfg.svh"
module ccu_clock_control_unit #(
   parameter int unsigned TIMEOUT_CYC = `CCU_SW_TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // oscillator status pins
   input  wire ccu_pkg::ccu_osc_t osc_ready,
   input  wire logic              fext_fail,
   // power mode events from the same clock domain
   input  wire logic              halt_exit,
   input  wire logic              active_halt_entry,
   // clock controls
   output ccu_pkg::ccu_osc_t      osc_en,
   output ccu_pkg::ccu_src_t      master_sel,
   output ccu_pkg::ccu_div_t      div_cfg,
   output logic [14:0]            periph_gate,
   output logic                   clk_out_en,
   output logic                   fail_monitor_en,
   output logic [2:0]             fint_trim,
   output logic                   regulator_off,
   output logic                   switch_notify
);
   import ccu_pkg::*;

   ccu_osc_t   osc_en_r;
   ccu_src_t   master_r;
   ccu_src_t   tgt_r;
   ccu_src_t   old_r;
   ccu_swst_t  sw_st_r;
   ccu_swst_t  sw_st_nxt;
   ccu_div_t   div_r;
   logic [14:0] gate_r;
   logic [31:0] prdata_r;
   logic [15:0] tmo_r;
   logic [2:0] trim_r;
   logic [3:0] s1_r;
   logic [3:0] s2_r;
   logic       regoff_opt_r;
   logic       fwake_r;
   logic       regoff_r;
   logic       sw_en_r;
   logic       busy_r;
   logic       irq_en_r;
   logic       auto_r;
   logic       old_off_r;
   logic       done_r;
   logic       fail_r;
   logic       aux_r;
   logic       mon_r;
   logic       cco_r;
   logic       wr;
   logic       rd_setup;
   logic       hit;
   logic       tgt_rdy;
   logic       sw_ok;
   logic       sw_tmo;
   logic       css_trip;
   logic       fwake_hit;
   logic [1:0] tgt_idx;
   logic [1:0] old_idx;

   // pin inputs pass two flops; only s2_r is read by logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= 4'h0;
         s2_r <= 4'h0;
      end else begin
         s1_r <= {fext_fail, osc_ready};
         s2_r <= s1_r;
      end
   end

   // apb decode; slave never inserts wait states
   assign wr       = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign hit      = (paddr == `CCU_OFS_OSC)  || (paddr == `CCU_OFS_SWCTL) ||
                     (paddr == `CCU_OFS_SWTGT) || (paddr == `CCU_OFS_DIV)  ||
                     (paddr == `CCU_OFS_GATE) || (paddr == `CCU_OFS_MISC);
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~hit;

   // source code to oscillator bit; source codes and the {sint,fext,fint} vectors differ
   assign tgt_idx   = (tgt_r == CCU_SRC_SINT) ? 2'h2 : ((tgt_r == CCU_SRC_FEXT) ? 2'h1 : 2'h0);
   assign old_idx   = (old_r == CCU_SRC_SINT) ? 2'h2 : ((old_r == CCU_SRC_FEXT) ? 2'h1 : 2'h0);

   // event terms shared by several registers
   assign tgt_rdy   = s2_r[tgt_idx];
   assign sw_ok     = (sw_st_r == CCU_SW_WAIT) && busy_r && tgt_rdy;
   assign sw_tmo    = (sw_st_r == CCU_SW_WAIT) && busy_r && !tgt_rdy &&
                      (tmo_r == 16'(TIMEOUT_CYC - 1));
   assign css_trip  = mon_r && s2_r[3] && (master_r == CCU_SRC_FEXT);
   assign fwake_hit = halt_exit && fwake_r;

   // read data captured in the setup phase so prdata comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
      end else if (rd_setup) begin
         if (paddr == `CCU_OFS_OSC) begin
            prdata_r <= {21'h0, s2_r[2:0], 3'h0, fwake_r, regoff_opt_r, osc_en_r};
         end else if (paddr == `CCU_OFS_SWCTL) begin
            prdata_r <= {22'h0, master_r, aux_r, fail_r, done_r, old_off_r,
                         auto_r, irq_en_r, busy_r, sw_en_r};
         end else if (paddr == `CCU_OFS_SWTGT) begin
            prdata_r <= {30'h0, tgt_r};
         end else if (paddr == `CCU_OFS_DIV) begin
            prdata_r <= {27'h0, div_r.cpu_div, div_r.fint_div};
         end else if (paddr == `CCU_OFS_GATE) begin
            prdata_r <= {17'h0, gate_r};
         end else if (paddr == `CCU_OFS_MISC) begin
            prdata_r <= {13'h0, div_r.esm_src, div_r.conv_div, div_r.cco_div,
                         div_r.awu_div, div_r.pll_div, div_r.pll_en,
                         div_r.dbg_div2, trim_r, 1'b0, cco_r, mon_r};
         end else begin
            prdata_r <= 32'h0;
         end
      end
   end
   assign prdata = prdata_r;

   // oscillator enables: software, switch sequencer, failure and wakeup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_en_r <= `CCU_RST_OSC;
      end else begin
         if (wr && paddr == `CCU_OFS_OSC) begin
            osc_en_r.fint <= pwdata[`CCU_OSC_FINT];
            osc_en_r.fext <= pwdata[`CCU_OSC_FEXT];
            osc_en_r.sint <= pwdata[`CCU_OSC_SINT];
         end
         // the target must run while the switch waits for it
         if (sw_st_r == CCU_SW_WAIT && busy_r) begin
            osc_en_r[tgt_idx] <= 1'b1;
         end
         // the old source stops only after the mux has left it
         if (sw_st_r == CCU_SW_COMMIT && old_off_r && old_r != master_r) begin
            osc_en_r[old_idx] <= 1'b0;
         end
         if (css_trip || fwake_hit) begin
            osc_en_r.fint <= 1'b1;
         end
      end
   end

   // power options; regulator cut is a level held through active-halt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regoff_opt_r <= 1'b0;
         fwake_r      <= 1'b0;
         regoff_r     <= 1'b0;
      end else begin
         if (wr && paddr == `CCU_OFS_OSC) begin
            regoff_opt_r <= pwdata[`CCU_OSC_REGOFF];
            fwake_r      <= pwdata[`CCU_OSC_FWAKE];
         end
         if (active_halt_entry && regoff_opt_r) begin
            regoff_r <= 1'b1;
         end else if (halt_exit) begin
            regoff_r <= 1'b0;
         end
      end
   end

   // switch configuration bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_r  <= 1'b0;
         auto_r    <= 1'b0;
         old_off_r <= 1'b0;
      end else if (wr && paddr == `CCU_OFS_SWCTL) begin
         irq_en_r  <= pwdata[`CCU_SW_IRQEN];
         auto_r    <= pwdata[`CCU_SW_AUTO];
         old_off_r <= pwdata[`CCU_SW_OLDOFF];
      end
   end

   // target register; a write arms the switch, unused code 3 maps to fast internal
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tgt_r <= CCU_SRC_FINT;
      end else if (wr && paddr == `CCU_OFS_SWTGT && !busy_r) begin
         tgt_r <= (pwdata[1:0] == 2'h3) ? CCU_SRC_FINT : ccu_src_t'(pwdata[1:0]);
      end
   end

   // busy and enable: an abort clear beats a simultaneous enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_r  <= 1'b0;
         sw_en_r <= 1'b0;
      end else begin
         if (wr && paddr == `CCU_OFS_SWCTL && !pwdata[`CCU_SW_BUSY]) begin
            busy_r  <= 1'b0;
            sw_en_r <= 1'b0;
         end else if (sw_ok || sw_tmo) begin
            busy_r  <= 1'b0;
            sw_en_r <= 1'b0;
         end else begin
            if (wr && paddr == `CCU_OFS_SWTGT) begin
               busy_r <= 1'b1;
            end
            if (wr && paddr == `CCU_OFS_SWCTL) begin
               sw_en_r <= pwdata[`CCU_SW_EN];
            end
         end
      end
   end

   // outcome flags, write one to clear; a new outcome wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_r <= 1'b0;
         fail_r <= 1'b0;
      end else begin
         if (sw_ok) begin
            done_r <= 1'b1;
         end else if (wr && paddr == `CCU_OFS_SWCTL && pwdata[`CCU_SW_DONE]) begin
            done_r <= 1'b0;
         end
         if (sw_tmo) begin
            fail_r <= 1'b1;
         end else if (wr && paddr == `CCU_OFS_SWCTL && pwdata[`CCU_SW_FAIL]) begin
            fail_r <= 1'b0;
         end
      end
   end
   assign switch_notify = done_r & irq_en_r;

   // switch sequencer: manual waits for enable, automatic runs on target write
   always_comb begin
      sw_st_nxt = sw_st_r;
      case (sw_st_r)
         CCU_SW_IDLE: begin
            if (busy_r && (sw_en_r || auto_r)) begin
               sw_st_nxt = CCU_SW_WAIT;
            end
         end
         CCU_SW_WAIT: begin
            if (!busy_r) begin
               sw_st_nxt = CCU_SW_IDLE;
            end else if (sw_ok) begin
               sw_st_nxt = CCU_SW_COMMIT;
            end else if (sw_tmo) begin
               sw_st_nxt = CCU_SW_IDLE;
            end
         end
         CCU_SW_COMMIT: begin
            sw_st_nxt = CCU_SW_IDLE;
         end
         default: begin
            sw_st_nxt = CCU_SW_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_st_r <= CCU_SW_IDLE;
      end else begin
         sw_st_r <= sw_st_nxt;
      end
   end

   // stabilization timer, restarted on every entry to the wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmo_r <= 16'h0;
      end else if (sw_st_r != CCU_SW_WAIT) begin
         tmo_r <= 16'h0;
      end else if (tmo_r != 16'(TIMEOUT_CYC - 1)) begin
         tmo_r <= tmo_r + 16'h1;
      end
   end

   // master select moves through the switch only to a running, stable source;
   // failure and wakeup force fast internal without checking its ready bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_r <= CCU_SRC_FINT;
         old_r    <= CCU_SRC_FINT;
         aux_r    <= 1'b0;
      end else if (css_trip) begin
         master_r <= CCU_SRC_FINT;
         aux_r    <= 1'b1;
      end else if (fwake_hit) begin
         master_r <= CCU_SRC_FINT;
      end else if (sw_ok) begin
         old_r    <= master_r;
         master_r <= tgt_r;
         aux_r    <= 1'b0;
      end
   end

   // dividers and misc settings in one process so the divider struct has one driver;
   // failure recovery forces the fast internal divide by eight
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r.fint_div <= `CCU_RST_FINT_DIV;
         div_r.cpu_div  <= `CCU_RST_CPU_DIV;
         mon_r          <= 1'b0;
         cco_r          <= 1'b0;
         trim_r         <= 3'h0;
         div_r.dbg_div2 <= `CCU_RST_DBG_DIV2;
         div_r.pll_en   <= 1'b0;
         div_r.pll_div  <= `CCU_RST_PLL_DIV;
         div_r.awu_div  <= `CCU_RST_AWU_DIV;
         div_r.cco_div  <= `CCU_RST_CCO_DIV;
         div_r.conv_div <= `CCU_RST_CONV_DIV;
         div_r.esm_src  <= 1'b0;
      end else begin
         if (css_trip) begin
            div_r.fint_div <= `CCU_RST_FINT_DIV;
         end else if (wr && paddr == `CCU_OFS_DIV) begin
            div_r.fint_div <= pwdata[1:0];
            div_r.cpu_div  <= pwdata[4:2];
         end
         if (wr && paddr == `CCU_OFS_MISC) begin
            mon_r          <= pwdata[0];
            cco_r          <= pwdata[1];
            trim_r         <= pwdata[5:3];
            div_r.dbg_div2 <= pwdata[6];
            div_r.pll_en   <= pwdata[7];
            div_r.pll_div  <= pwdata[9:8];
            div_r.awu_div  <= pwdata[12:10];
            div_r.cco_div  <= pwdata[15:13];
            div_r.conv_div <= pwdata[17:16];
            div_r.esm_src  <= pwdata[18];
         end
      end
   end

   // gates update only at a clock edge so the gate cells see clean enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_r <= `CCU_RST_GATE;
      end else if (wr && paddr == `CCU_OFS_GATE) begin
         gate_r <= pwdata[14:0];
      end
   end

   // all controls but switch_notify leave from flops; downstream cells latch on the low phase
   assign osc_en          = osc_en_r;
   assign master_sel      = master_r;
   assign div_cfg         = div_r;
   assign periph_gate     = gate_r;
   assign clk_out_en      = cco_r;
   assign fail_monitor_en = mon_r;
   assign fint_trim       = trim_r;
   assign regulator_off   = regoff_r;
endmodule : ccu_clock_control_unit
`default_nettype wire

// ===== bench/ccu_clock_control_unit_chk.sv
// checker: port-level assertions for the clock control unit
`timescale 1ns/100ps
`default_nettype none
module ccu_clock_control_unit_chk #(
   parameter int unsigned TIMEOUT_CYC = 16
) (
   // clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // apb
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // events
   input wire logic              fext_fail,
   input wire logic              halt_exit,
   input wire logic              active_halt_entry,
   // controls
   input wire ccu_pkg::ccu_osc_t osc_en,
   input wire ccu_pkg::ccu_src_t master_sel,
   input wire ccu_pkg::ccu_div_t div_cfg,
   input wire logic [14:0]       periph_gate,
   input wire logic              clk_out_en,
   input wire logic              fail_monitor_en,
   input wire logic [2:0]        fint_trim,
   input wire logic              regulator_off,
   input wire logic              switch_notify
);
   import ccu_pkg::*;
   logic wr;
   logic fwake_r;
   logic regoff_r;
   // completed write strobe
   assign wr = psel && penable && pwrite && pready;
   // shadow of the power options, the only hidden state these checks need
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {fwake_r, regoff_r} <= 2'h0;
      end else if (wr && paddr == 12'h000) begin
         {fwake_r, regoff_r} <= pwdata[4:3];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_reset_state: assert property ($rose(presetn) |-> osc_en == 3'h1 &&
      master_sel == CCU_SRC_FINT && periph_gate == 15'h7FFF && !clk_out_en)
      else $error("outputs wrong after reset");
   a_err_map: assert property (psel && penable |-> pslverr == (paddr > 12'h014))
      else $error("error response wrong");
   a_unmap_zero: assert property (psel && !penable && !pwrite && paddr > 12'h014
      |=> prdata == 32'h0) else $error("unmapped read not zero");
   a_gate_wr: assert property (wr && paddr == 12'h010
      |=> 32'(periph_gate) == ($past(pwdata) & 32'h7FFF)) else $error("gate write lost");
   a_div_wr: assert property (wr && paddr == 12'h00C
      |=> 32'({div_cfg.cpu_div, div_cfg.fint_div}) == ($past(pwdata) & 32'h1F))
      else $error("divider write lost");
   a_misc_wr: assert property (wr && paddr == 12'h014
      |=> 32'({fint_trim, 1'h0, clk_out_en, fail_monitor_en}) == ($past(pwdata) & 32'h3B))
      else $error("misc write lost");
   a_osc_wr: assert property (wr && paddr == 12'h000 && !halt_exit
      |=> 32'(osc_en) == ($past(pwdata) & 32'h7)) else $error("oscillator write lost");
   a_reg_off: assert property (active_halt_entry && regoff_r && !halt_exit
      |=> regulator_off) else $error("regulator not off in active halt");
   a_reg_on: assert property (halt_exit |=> !regulator_off)
      else $error("regulator not back on");
   a_fast_wake: assert property (halt_exit && fwake_r
      |=> master_sel == CCU_SRC_FINT && osc_en.fint) else $error("fast wakeup missed");
   a_fail_recov: assert property ((fail_monitor_en && master_sel == CCU_SRC_FEXT
      && fext_fail) [*3] |-> ##[0:3] master_sel == CCU_SRC_FINT && div_cfg.fint_div == 2'h3)
      else $error("no recovery from crystal failure");
   // main scenarios reached
   c_switch: cover property ($rose(switch_notify));
   c_reg_off: cover property ($fell(regulator_off));
   c_unmap: cover property (psel && penable && pslverr);
endmodule : ccu_clock_control_unit_chk
bind ccu_clock_control_unit ccu_clock_control_unit_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .fext_fail, .halt_exit, .active_halt_entry, .osc_en, .master_sel,
   .div_cfg, .periph_gate, .clk_out_en, .fail_monitor_en, .fint_trim,
   .regulator_off, .switch_notify
);
`default_nettype wire

// ===== bench/ccu_clock_control_unit_tb.sv
// self-checking testbench for the clock control unit
`timescale 1ns/100ps
`default_nettype none
module ccu_clock_control_unit_tb;
   import ccu_pkg::*;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   ccu_osc_t    osc_ready;
   logic        fext_fail;
   logic        halt_exit;
   logic        active_halt_entry;
   ccu_osc_t    osc_en;
   ccu_src_t    master_sel;
   ccu_div_t    div_cfg;
   ccu_div_t    div_exp;
   logic [14:0] periph_gate;
   logic        clk_out_en;
   logic        fail_monitor_en;
   logic [2:0]  fint_trim;
   logic        regulator_off;
   logic        switch_notify;
   logic [63:0] exp_q[$];
   logic [63:0] ent;
   logic [31:0] rnd;
   int          n_mismatch;
   int          compares;
   int          cyc;
   int          i;

   // short switch timeout keeps the failure case quick
   ccu_clock_control_unit #(.TIMEOUT_CYC(16)) u_ccu_clock_control_unit (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .osc_ready, .fext_fail, .halt_exit, .active_halt_entry,
      .osc_en, .master_sel, .div_cfg, .periph_gate, .clk_out_en,
      .fail_monitor_en, .fint_trim, .regulator_off, .switch_notify
   );

   // 25 MHz clock
   initial pclk = 1'b0;
   always #20 pclk = ~pclk;

   task cmp(input logic [31:0] act, input logic [31:0] exp);
      compares++;
      if (act !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp);
      end
   endtask : cmp

   task final_report;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   // one apb transfer, held until pready is seen at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   // a read notes its expected word and mask for the monitor
   task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
      exp_q.push_back({m, e});
      apb(1'b0, a, 32'h0);
   endtask : rd

   task tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : tick

   // bounded wait for the master clock to reach a source
   task wait_src(input ccu_src_t s);
      for (int k = 0; k < 20 && master_sel !== s; k++) @(posedge pclk);
      tick(1);
   endtask : wait_src

   // one-cycle power event: exit when ex is set, else active-halt entry
   task pulse_halt(input logic ex);
      @(posedge pclk);
      halt_exit         <= ex;
      active_halt_entry <= !ex;
      @(posedge pclk);
      halt_exit         <= 1'b0;
      active_halt_entry <= 1'b0;
      #1;
   endtask : pulse_halt

   // read data is taken at the edge that completes the access
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         ent = exp_q.pop_front();
         cmp(prdata & ent[63:32], ent[31:0]);
      end
   end

   // hang guard, far above the expected run length
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         final_report();
      end
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      osc_ready = 3'h7;
      fext_fail = 1'b0;
      halt_exit = 1'b0;
      active_halt_entry = 1'b0;
      void'($urandom(92274));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      tick(1);
      // reset state at the pins and through the bus
      div_exp = '0;
      div_exp.fint_div = 2'h3;
      div_exp.dbg_div2 = 1'b1;
      div_exp.pll_div = 2'h2;
      div_exp.conv_div = 2'h3;
      cmp(32'(div_cfg), 32'(div_exp));
      cmp({26'h0, fint_trim, clk_out_en, fail_monitor_en, regulator_off}, 32'h0);
      cmp({14'h0, periph_gate, osc_en}, {14'h0, 15'h7FFF, 3'h1});
      cmp(32'(master_sel), 32'h0);
      rd(12'h000, 32'h701);
      rd(12'h00C, 32'h3);
      rd(12'h014, 32'h30240);
      rd(12'h010, 32'h7FFF);
      rd(12'h004, 32'h0);
      // every divider code, oscillator pattern and a random gate set
      for (i = 0; i < 8; i++) begin
         rnd = {27'h0, 3'(i), 2'(i)};
         wr(12'h00C, rnd);
         rd(12'h00C, rnd);
         wr(12'h000, 32'(i));
         rd(12'h000, 32'h700 | 32'(i));
         cmp(32'(osc_en), 32'(i));
         rnd = $urandom & 32'h7FFF;
         wr(12'h010, rnd);
         cmp(32'(periph_gate), rnd);
      end
      wr(12'h000, 32'h1);
      rnd = $urandom & 32'h7FFFA;
      wr(12'h014, rnd);
      rd(12'h014, rnd);
      cmp(32'(clk_out_en), 32'(rnd[1]));
      wr(12'h014, 32'h30240);
      wr(12'h018, 32'hFFFFFFFF);
      rd(12'h018, 32'h0);
      // automatic switch held back until the external oscillator is stable
      osc_ready <= 3'h1;
      wr(12'h004, 32'h1E);
      wr(12'h008, 32'h2);
      tick(10);
      cmp(32'(master_sel), 32'h0);
      cmp(32'(osc_en), 32'h3);
      rd(12'h004, 32'h1E);
      osc_ready <= 3'h3;
      wait_src(CCU_SRC_FEXT);
      tick(3);
      cmp(32'(master_sel), 32'h2);
      cmp(32'(osc_en), 32'h2);
      cmp(32'(switch_notify), 32'h1);
      rd(12'h004, 32'h23C);
      wr(12'h004, 32'h3A);
      cmp(32'(switch_notify), 32'h0);
      // manual switch to a target that never settles ends in failure
      wr(12'h004, 32'h2);
      wr(12'h008, 32'h1);
      wr(12'h004, 32'h3);
      tick(40);
      cmp(32'(master_sel), 32'h2);
      rd(12'h004, 32'h240, 32'h362);
      wr(12'h004, 32'h42);
      // clearing busy beats an enable in the same write
      wr(12'h008, 32'h1);
      wr(12'h004, 32'h1);
      tick(40);
      rd(12'h004, 32'h200, 32'h363);
      cmp(32'(master_sel), 32'h2);
      // crystal failure with the monitor on falls back to the internal clock
      wr(12'h00C, 32'h0);
      wr(12'h014, 32'h30241);
      fext_fail <= 1'b1;
      wait_src(CCU_SRC_FINT);
      cmp(32'(div_cfg.fint_div), 32'h3);
      rd(12'h004, 32'h80, 32'h80);
      fext_fail <= 1'b0;
      wr(12'h014, 32'h30240);
      // back onto the crystal so the wakeup really has to move the master clock
      wr(12'h004, 32'hA);
      wr(12'h008, 32'h2);
      wait_src(CCU_SRC_FEXT);
      cmp(32'(master_sel), 32'h2);
      // regulator shutdown in active halt, fast wakeup on exit
      wr(12'h000, 32'h1A);
      pulse_halt(1'b0);
      cmp(32'(regulator_off), 32'h1);
      pulse_halt(1'b1);
      cmp({30'h0, regulator_off, osc_en.fint}, 32'h1);
      cmp(32'(master_sel), 32'h0);
      final_report();
   end
endmodule : ccu_clock_control_unit_tb
`default_nettype wire
